// File: inc/sbcdma_defines.svh
// Constants for the system bus control and DMA arbitration block.
// Assumes a single 50 MHz mclk with synchronous active-high srst.
//
// Overview of operation
// - Status code selects command strobe
// - I/O write drives normal and early strobes
// - Address latch strobe in first period
// - Data enable opens the transceiver
// - Direction high on write, low on read
// - No commands while DMA owns bus
// - DMA beats the processors, except straight after its own cycle
// - DMA ownership drops enable and ready
// - Grant only at idle/halt without lock
// - Channel priority fixed, zero highest
// - Channel requests sampled every clock
// - Refresh cycle every 16 microseconds
// - Refresh row increments, wraps at 256
// - Page bits extend 64K to 1M
// - Page port drives top address in DMA, except on channel 2
// - DMA clock 50%, processor clock 30%
// - Reset synchronized, DMA forced idle
// - Address latch transparent, holds at fall
// - Upper byte strobed, low byte passed straight through
// - Page driver chosen by active channel
`ifndef SBCDMA_DEFINES_SVH
`define SBCDMA_DEFINES_SVH

// ==========================================================
// Status codes
`define SBC_ST_IRQ_ACK   3'h0
`define SBC_ST_IO_RD     3'h1
`define SBC_ST_IO_WR     3'h2
`define SBC_ST_HALT      3'h3
`define SBC_ST_FETCH     3'h4
`define SBC_ST_MEM_RD    3'h5
`define SBC_ST_MEM_WR    3'h6
`define SBC_ST_PASSIVE   3'h7

// ==========================================================
// Timing
`define SBC_MCLK_HZ      50000000
`define SBC_SYS_CLK_HZ   4915200
`define SBC_REFRESH_US   16
`define SBC_REFRESH_CYC  ((`SBC_MCLK_HZ / 1000000) * `SBC_REFRESH_US)
`define SBC_ROWS         256
// System clock from mclk: period of 10 mclk (5 MHz nearest)
`define SBC_SYS_DIV      10
`define SBC_SYS_HI33     3
`define SBC_SYS_HI50     5
// Bus cycle periods T1..T4 each one system clock
`define SBC_DMA_PERIODS  4

`endif

// File: inc/sbcdma_pkg.sv
// Types for the system bus control and DMA arbitration block.
// Assumes the defines header is included by users of numbers.
`default_nettype none
package sbcdma_pkg;
   typedef enum logic [1:0] {SBCDMA_OWN_CPU, SBCDMA_OWN_WAIT, SBCDMA_OWN_DMA} sbcdma_own_t;
   typedef enum logic [2:0] {SBCDMA_T_IDLE, SBCDMA_T1, SBCDMA_T2, SBCDMA_T3,
                             SBCDMA_T4} sbcdma_tstate_t;
endpackage
`default_nettype wire

// File: logic/sbcdma_sync3.sv
// Three-stage input synchronizer with agreement filter, per bit.
// Assumes input is asynchronous to mclk.
`default_nettype none
module sbcdma_sync3
   import sbcdma_pkg::*;
#(
   parameter int W = 4
) (
   // Clock and reset
   input  wire logic         mclk,
   input  wire logic         srst,
   // Data
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] s1_reg, s2_reg, s3_reg, out_reg;
   logic [W-1:0] out_next;

   // ==========================================================
   // Filter: change counts once stages two and three agree
   always_comb begin
      out_next = out_reg;
      for (int i = 0; i < W; i++) begin
         if (s2_reg[i] == s3_reg[i]) begin
            out_next[i] = s2_reg[i];
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         s1_reg  <= '0;
         s2_reg  <= '0;
         s3_reg  <= '0;
         out_reg <= '0;
      end else begin
         s1_reg  <= din;
         s2_reg  <= s1_reg;
         s3_reg  <= s2_reg;
         out_reg <= out_next;
      end
   end

   assign dout = out_reg;
endmodule
`default_nettype wire

// File: logic/sbcdma_bus_ctrl.sv
// Bus command decode, single-bus arbiter and DMA channel control.
// Assumes processor status and lock arrive asynchronously on pins;
// DMA channel requests are asynchronous; one mclk domain throughout.
`include "sbcdma_defines.svh"
`default_nettype none
module sbcdma_bus_ctrl
   import sbcdma_pkg::*;
(
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        srst,
   // Processor status
   input  wire logic [2:0]  status_n,
   input  wire logic        lock_n,
   input  wire logic [19:0] cpu_addr,
   // DMA channel requests and page port
   input  wire logic [3:0]  chan_req,
   input  wire logic [7:0]  page_port_out,
   input  wire logic [15:0] dma_addr,
   // Clocks out
   output logic             system_clock,
   output logic             dma_clock,
   output logic             sys_reset,
   // Command strobes
   output logic             irq_ack_strobe_n,
   output logic             io_read_strobe_n,
   output logic             io_write_strobe_n,
   output logic             early_io_write_strobe_n,
   output logic             mem_read_strobe_n,
   output logic             mem_write_strobe_n,
   // Bus control
   output logic             addr_latch_strobe,
   output logic             xcvr_enable,
   output logic             xcvr_dir_out,
   output logic             bus_owner_enable_n,
   output logic             cpu_ready,
   // DMA status
   output logic [3:0]       chan_ack,
   output logic             dma_upper_addr_strobe,
   output logic [19:0]      sys_addr,
   output logic [7:0]       refresh_row
);
   // ==========================================================
   // Input synchronizers
   logic [3:0] req_s;
   logic [3:0] st_s;
   logic [2:0] st_n;
   logic       lock_s_n;

   // Requests seen on every mclk edge
   sbcdma_sync3 #(.W(4)) u_req_sync (
      .mclk (mclk),
      .srst (srst),
      .din  (chan_req),
      .dout (req_s)
   );

   // Inverted so cleared stages read passive and unlocked after reset
   sbcdma_sync3 #(.W(4)) u_st_sync (
      .mclk (mclk),
      .srst (srst),
      .din  ({~lock_n, ~status_n}),
      .dout (st_s)
   );
   assign st_n     = ~st_s[2:0];
   assign lock_s_n = ~st_s[3];

   // ==========================================================
   // Clock dividers and reset synchronization
   logic [3:0] div_reg, div_next;
   logic       sys_edge;
   logic       rst_reg, rst_next;

   always_comb begin
      div_next = (div_reg == 4'(`SBC_SYS_DIV - 1)) ? 4'h0 : div_reg + 4'h1;
      rst_next = srst;
   end

   always_ff @(posedge mclk) begin
      rst_reg <= rst_next;
      if (srst) begin
         div_reg <= 4'h0;
      end else begin
         div_reg <= div_next;
      end
   end

   // Two duty cycles from one count keep both clocks in phase
   assign system_clock = (div_reg < 4'(`SBC_SYS_HI33));
   assign dma_clock    = (div_reg < 4'(`SBC_SYS_HI50));
   assign sys_edge     = (div_reg == 4'(`SBC_SYS_DIV - 1));
   assign sys_reset    = rst_reg;

   // ==========================================================
   // Refresh timer and row counter
   localparam int REF_CYC = `SBC_REFRESH_CYC;
   logic [9:0] ref_cnt_reg, ref_cnt_next;
   logic       ref_pend_reg, ref_pend_next;
   logic [7:0] row_reg, row_next;
   logic       ref_tick;
   logic       refresh_done;

   assign ref_tick = (ref_cnt_reg == 10'(REF_CYC - 1));

   always_comb begin
      ref_cnt_next  = ref_tick ? 10'h000 : ref_cnt_reg + 10'h001;
      ref_pend_next = ref_pend_reg;
      row_next      = row_reg;
      if (refresh_done) begin
         ref_pend_next = 1'b0;
         row_next      = row_reg + 8'h01;
      end
      // A new tick wins over the clear of the old one
      if (ref_tick) begin
         ref_pend_next = 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         ref_cnt_reg  <= 10'h000;
         ref_pend_reg <= 1'b0;
         row_reg      <= 8'h00;
      end else begin
         ref_cnt_reg  <= ref_cnt_next;
         ref_pend_reg <= ref_pend_next;
         row_reg      <= row_next;
      end
   end
   assign refresh_row = row_reg;

   // ==========================================================
   // Channel priority
   function automatic logic [3:0] pick_chan(input logic [3:0] r);
      logic [3:0] g;
      g = 4'h0;
      if (r[0]) begin
         g = 4'h1;
      end else if (r[1]) begin
         g = 4'h2;
      end else if (r[2]) begin
         g = 4'h4;
      end else if (r[3]) begin
         g = 4'h8;
      end
      return g;
   endfunction

   logic [3:0] eff_req;
   logic       dma_req;
   // Refresh request folds onto channel 2
   assign eff_req = {req_s[3], req_s[2] | ref_pend_reg, req_s[1:0]};
   assign dma_req = |eff_req;

   // ==========================================================
   // Arbiter and DMA cycle sequencer
   sbcdma_own_t    own_reg, own_next;
   sbcdma_tstate_t dt_reg, dt_next;
   logic [3:0]     ack_reg, ack_next;
   logic           cpu_quiet;
   logic           gap_reg, gap_next;

   // Grant only at idle/halt with lock released
   assign cpu_quiet = ((st_n == `SBC_ST_PASSIVE) || (st_n == `SBC_ST_HALT))
                      && lock_s_n;

   always_comb begin
      own_next = own_reg;
      dt_next  = dt_reg;
      ack_next = ack_reg;
      gap_next = gap_reg;
      refresh_done = 1'b0;
      if (sys_edge) begin
         unique case (own_reg)
            SBCDMA_OWN_CPU: begin
               // DMA beats the processors when the bus is free and status has left passive since the last DMA cycle ended
               if (dma_req && cpu_quiet && !gap_reg) begin
                  own_next = SBCDMA_OWN_DMA;
                  dt_next  = SBCDMA_T1;
                  ack_next = pick_chan(eff_req);
               end
               if (st_n != `SBC_ST_PASSIVE) begin
                  gap_next = 1'b0;
               end
            end
            SBCDMA_OWN_DMA: begin
               unique case (dt_reg)
                  SBCDMA_T1:   dt_next = SBCDMA_T2;
                  SBCDMA_T2:   dt_next = SBCDMA_T3;
                  SBCDMA_T3:   dt_next = SBCDMA_T4;
                  SBCDMA_T4: begin
                     // Single transfer: release after one cycle
                     dt_next  = SBCDMA_T_IDLE;
                     own_next = SBCDMA_OWN_WAIT;
                     refresh_done = ack_reg[2] && ref_pend_reg;
                     ack_next = 4'h0;
                     gap_next = 1'b1;
                  end
                  default:     dt_next = SBCDMA_T_IDLE;
               endcase
            end
            SBCDMA_OWN_WAIT: begin
               own_next = SBCDMA_OWN_CPU;
            end
            default: own_next = SBCDMA_OWN_CPU;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         own_reg <= SBCDMA_OWN_CPU;
         dt_reg  <= SBCDMA_T_IDLE;
         ack_reg <= 4'h0;
         gap_reg <= 1'b0;
      end else begin
         own_reg <= own_next;
         dt_reg  <= dt_next;
         ack_reg <= ack_next;
         gap_reg <= gap_next;
      end
   end

   logic cpu_owns;
   assign cpu_owns = (own_reg == SBCDMA_OWN_CPU);

   // ==========================================================
   // Processor bus cycle tracker
   sbcdma_tstate_t ct_reg, ct_next;
   logic [2:0]     cmd_reg, cmd_next;
   logic           cmd_act;

   assign cmd_act = (st_n != `SBC_ST_PASSIVE) && (st_n != `SBC_ST_HALT);

   always_comb begin
      ct_next  = ct_reg;
      cmd_next = cmd_reg;
      if (sys_edge) begin
         unique case (ct_reg)
            SBCDMA_T_IDLE: begin
               // Decoder disabled while DMA holds the bus
               if (cmd_act && cpu_owns) begin
                  ct_next  = SBCDMA_T1;
                  cmd_next = st_n;
               end
            end
            SBCDMA_T1:   ct_next = SBCDMA_T2;
            SBCDMA_T2:   ct_next = SBCDMA_T3;
            SBCDMA_T3:   ct_next = cpu_owns ? SBCDMA_T4 : SBCDMA_T3;
            SBCDMA_T4:   ct_next = SBCDMA_T_IDLE;
            default:     ct_next = SBCDMA_T_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         ct_reg  <= SBCDMA_T_IDLE;
         cmd_reg <= `SBC_ST_PASSIVE;
      end else begin
         ct_reg  <= ct_next;
         cmd_reg <= cmd_next;
      end
   end

   // ==========================================================
   // Command strobes and transceiver control
   logic in_data, cmd_on, early_on;
   assign in_data  = (ct_reg == SBCDMA_T2) || (ct_reg == SBCDMA_T3);
   assign cmd_on   = cpu_owns && ((ct_reg == SBCDMA_T3) ||
                     (ct_reg == SBCDMA_T2 && cmd_reg != `SBC_ST_IO_WR &&
                      cmd_reg != `SBC_ST_MEM_WR));
   assign early_on = cpu_owns && in_data;

   always_comb begin
      irq_ack_strobe_n        = !(cmd_on && cmd_reg == `SBC_ST_IRQ_ACK);
      io_read_strobe_n        = !(cmd_on && cmd_reg == `SBC_ST_IO_RD);
      io_write_strobe_n       = !(cmd_on && cmd_reg == `SBC_ST_IO_WR);
      early_io_write_strobe_n = !(early_on && cmd_reg == `SBC_ST_IO_WR);
      mem_read_strobe_n       = !(cmd_on && (cmd_reg == `SBC_ST_MEM_RD ||
                                  cmd_reg == `SBC_ST_FETCH));
      mem_write_strobe_n      = !(cmd_on && cmd_reg == `SBC_ST_MEM_WR);
   end

   // Latch strobe high across the first period only
   assign addr_latch_strobe  = cpu_owns && (ct_reg == SBCDMA_T1);
   assign xcvr_enable        = cpu_owns && in_data;
   assign xcvr_dir_out       = (cmd_reg == `SBC_ST_IO_WR) ||
                               (cmd_reg == `SBC_ST_MEM_WR);
   assign bus_owner_enable_n = !cpu_owns;
   assign cpu_ready          = cpu_owns;
   assign chan_ack           = ack_reg;
   assign dma_upper_addr_strobe = (dt_reg == SBCDMA_T1);

   // ==========================================================
   // Address latches and page selection
   logic [19:0] cpu_lat_reg, cpu_lat_next;
   logic [7:0]  dma_hi_reg, dma_hi_next;
   logic [3:0]  page_bits;
   logic [19:0] addr_next, addr_reg;

   // Channel 1 uses upper nibble; channels 0 and 3 the lower
   assign page_bits = ack_reg[1] ? page_port_out[7:4] : page_port_out[3:0];

   always_comb begin
      cpu_lat_next = addr_latch_strobe ? cpu_addr : cpu_lat_reg;
      dma_hi_next  = dma_upper_addr_strobe ? dma_addr[15:8] : dma_hi_reg;
      if (own_reg == SBCDMA_OWN_DMA) begin
         // 64K native reach plus four page bits gives 1M
         addr_next = {page_bits, dma_hi_next, dma_addr[7:0]};
         if (ack_reg[2]) begin
            addr_next = {12'h000, row_reg};
         end
      end else begin
         addr_next = cpu_lat_next;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         cpu_lat_reg <= 20'h00000;
         dma_hi_reg  <= 8'h00;
         addr_reg    <= 20'h00000;
      end else begin
         cpu_lat_reg <= cpu_lat_next;
         dma_hi_reg  <= dma_hi_next;
         addr_reg    <= addr_next;
      end
   end
   assign sys_addr = addr_reg;
endmodule
`default_nettype wire

// File: dv/sbcdma_cpu_model.sv
// Processor and DMA requester model facing the bus control block.
// Assumes one 50 MHz mclk; drives its pins on the falling edge.
`default_nettype none
module sbcdma_cpu_model (
   // Clock
   input  wire logic        mclk,
   // Bench commands
   input  wire logic        go,
   input  wire logic [2:0]  code,
   input  wire logic        lock_req,
   input  wire logic [3:0]  want,
   output logic             busy,
   // Block side
   input  wire logic        cpu_ready,
   input  wire logic [3:0]  chan_ack,
   output logic [2:0]       status_n,
   output logic             lock_n,
   output logic [19:0]      cpu_addr,
   output logic [3:0]       chan_req
);
   int cnt = 0;

   initial begin
      status_n = 3'h7;
      lock_n = 1'b1;
      cpu_addr = 20'h0;
      chan_req = 4'h0;
      busy = 1'b0;
   end

   // ====
   // Status held 40 mclk, stretched while ready is low
   always @(negedge mclk) begin
      lock_n <= ~lock_req;
      chan_req <= want & ~chan_ack;
      if (go && !busy) begin
         busy <= 1'b1;
         cnt <= 0;
         status_n <= code;
         cpu_addr <= 20'h1c0de;
      end else if (busy) begin
         if (cpu_ready) cnt <= cnt + 1;
         if (cnt == 39) begin
            status_n <= 3'h7;
            busy <= 1'b0;
         end
      end else begin
         cpu_addr <= ~cpu_addr; // Released lines keep moving
      end
   end
endmodule
`default_nettype wire

// File: dv/sbcdma_bus_ctrl_monitor.sv
// Checker for the bus control and DMA arbitration block.
// Assumes it is bound onto sbcdma_bus_ctrl; one mclk domain.
`default_nettype none
module sbcdma_bus_ctrl_monitor (
   // Clock and reset
   input wire logic       mclk,
   input wire logic       srst,
   // Clocks and strobes
   input wire logic       system_clock,
   input wire logic       dma_clock,
   input wire logic       irq_ack_strobe_n,
   input wire logic       io_read_strobe_n,
   input wire logic       io_write_strobe_n,
   input wire logic       early_io_write_strobe_n,
   input wire logic       mem_read_strobe_n,
   input wire logic       mem_write_strobe_n,
   // Bus control and DMA
   input wire logic       addr_latch_strobe,
   input wire logic       xcvr_enable,
   input wire logic       xcvr_dir_out,
   input wire logic       bus_owner_enable_n,
   input wire logic       cpu_ready,
   input wire logic [3:0] chan_ack,
   input wire logic       dma_upper_addr_strobe,
   input wire logic [7:0] refresh_row
);
   wire logic [5:0] stb_n = {irq_ack_strobe_n, io_read_strobe_n, io_write_strobe_n,
                             early_io_write_strobe_n, mem_read_strobe_n, mem_write_strobe_n};

   // ====
   // Properties on mclk, quiet while reset is high except the reset output check
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (srst);

   cmd_own_a: assert property (stb_n != 6'h3f |-> !bus_owner_enable_n)
      else $error("command strobe while bus given away");
   ready_own_a: assert property (cpu_ready == !bus_owner_enable_n)
      else $error("ready disagrees with bus owner enable");
   ack_one_a: assert property ($onehot0(chan_ack))
      else $error("more than one channel granted");
   ack_own_a: assert property (|chan_ack |-> bus_owner_enable_n)
      else $error("grant while processor holds bus");
   early_wr_a: assert property ($fell(io_write_strobe_n) |-> !early_io_write_strobe_n)
      else $error("early write strobe missing");
   wr_dir_a: assert property (!(mem_write_strobe_n & io_write_strobe_n) |-> xcvr_dir_out)
      else $error("direction low on write");
   rd_dir_a: assert property (!(mem_read_strobe_n & io_read_strobe_n) |-> !xcvr_dir_out)
      else $error("direction high on read");
   xcvr_own_a: assert property (xcvr_enable |-> !bus_owner_enable_n)
      else $error("transceiver on while bus given away");
   ale_width_a: assert property ($rose(addr_latch_strobe) |-> addr_latch_strobe[*8])
      else $error("latch strobe too short");
   dma_stb_a: assert property ($rose(dma_upper_addr_strobe) |->
                               (dma_upper_addr_strobe && |chan_ack)[*8])
      else $error("upper address strobe outside grant");
   sys_duty_a: assert property ($rose(system_clock) |->
                                system_clock[*3] ##1 !system_clock[*7])
      else $error("system clock duty wrong");
   dma_duty_a: assert property ($rose(dma_clock) |-> dma_clock[*5] ##1 !dma_clock[*5])
      else $error("dma clock duty wrong");
   row_step_a: assert property ($changed(refresh_row) |->
                                refresh_row == $past(refresh_row) + 8'h01)
      else $error("refresh row did not step by one");
   reset_out_a: assert property (disable iff (1'b0) srst |=>
                                 stb_n == 6'h3f && chan_ack == 4'h0)
      else $error("outputs active in reset");

   // Main scenarios reached
   cover property (|chan_ack);
   cover property ($fell(io_write_strobe_n));
   cover property ($changed(refresh_row));
endmodule

bind sbcdma_bus_ctrl sbcdma_bus_ctrl_monitor u_sbcdma_bus_ctrl_monitor (.*);
`default_nettype wire

// File: dv/sbcdma_bus_ctrl_tb_top.sv
// Self-checking bench for the bus control and DMA arbitration block.
// Assumes the processor model file; one 50 MHz mclk.
`default_nettype none
module sbcdma_bus_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        mclk = 1'b0, srst = 1'b1, go = 1'b0, lk = 1'b0;
   logic [2:0]  code = 3'h7, st_n;
   logic [3:0]  want = 4'h0, req, ack;
   logic [7:0]  page = 8'ha5, row;
   logic [15:0] daddr = 16'h1234;
   logic [19:0] caddr, saddr;
   logic [5:0]  stb_n;
   logic        busy, lock_n, rdy, own_n, srs, ale, xen, xdir, dstb;
   int          error_cnt = 0, tests_run = 0;
   localparam logic [5:0] exp_stb [8] = '{6'h20, 6'h10, 6'h0c, 6'h00,
                                          6'h02, 6'h02, 6'h01, 6'h00};

   initial forever #10 mclk = ~mclk;

   // ====
   // Block and its processor side
   sbcdma_bus_ctrl u_sbcdma_bus_ctrl (.mclk(mclk), .srst(srst), .status_n(st_n),
      .lock_n(lock_n), .cpu_addr(caddr), .chan_req(req), .page_port_out(page),
      .dma_addr(daddr), .system_clock(), .dma_clock(), .sys_reset(srs),
      .irq_ack_strobe_n(stb_n[5]), .io_read_strobe_n(stb_n[4]),
      .io_write_strobe_n(stb_n[3]), .early_io_write_strobe_n(stb_n[2]),
      .mem_read_strobe_n(stb_n[1]), .mem_write_strobe_n(stb_n[0]),
      .addr_latch_strobe(ale), .xcvr_enable(xen), .xcvr_dir_out(xdir),
      .bus_owner_enable_n(own_n), .cpu_ready(rdy), .chan_ack(ack),
      .dma_upper_addr_strobe(dstb), .sys_addr(saddr), .refresh_row(row));
   sbcdma_cpu_model u_sbcdma_cpu_model (.mclk(mclk), .go(go), .code(code),
      .lock_req(lk), .want(want), .busy(busy), .cpu_ready(rdy), .chan_ack(ack),
      .status_n(st_n), .lock_n(lock_n), .cpu_addr(caddr), .chan_req(req));

   // ====
   // Shared checking and bounded waits
   task automatic chk(string nm, logic [19:0] seen, logic [19:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic wait_ack(logic on);
      int n;
      n = 0;
      while ((|ack) !== on) begin
         @(negedge mclk);
         n++;
         if (n > 400) begin
            chk("ack wait", {19'h0, |ack}, {19'h0, on});
            complete_run();
         end
      end
   endtask

   // One processor cycle; collects dir, xcvr, latch and strobes seen
   task automatic cpu_cycle(logic [2:0] c, output logic [8:0] s);
      int n, m;
      s = 9'h0;
      n = 0;
      m = 0;
      code <= c;
      go <= 1'b1;
      repeat (2) @(negedge mclk);
      go <= 1'b0;
      while (n < 30) begin
         @(negedge mclk);
         s = s | {(stb_n != 6'h3f) & xdir, xen, ale, ~stb_n};
         if (busy !== 1'b1) n++;
         m++;
         if (m > 800) begin
            chk("cycle end", {19'h0, n < 30}, 20'h0);
            complete_run();
         end
      end
   endtask

   // One DMA grant, then a processor cycle to space the next
   task automatic dma_one(logic [3:0] w, logic [3:0] ea, logic [19:0] ex);
      logic [8:0] s;
      int n;
      want <= want | w;
      wait_ack(1'b1);
      want <= want & ~ack;
      chk("grant", {16'h0, ack}, {16'h0, ea});
      chk("owner", {18'h0, own_n, rdy}, 20'h2);
      repeat (5) @(negedge mclk);
      chk("dma addr", saddr, ex);
      wait_ack(1'b0);
      for (n = 0; n < 100 && own_n !== 1'b0; n++) @(negedge mclk);
      chk("bus back", {18'h0, own_n, rdy}, 20'h1);
      cpu_cycle(3'h5, s);
   endtask

   task automatic reset_chk();
      srst <= 1'b1;
      repeat (4) @(negedge mclk);
      chk("in reset", {12'h0, stb_n, own_n, srs}, {12'h0, 6'h3f, 1'b0, 1'b1});
      chk("reset ack", {16'h0, ack}, 20'h0);
      srst <= 1'b0;
   endtask

   // ====
   // Scenarios
   task automatic t_decode();
      logic [8:0] s;
      for (int c = 0; c < 8; c++) begin
         cpu_cycle(c[2:0], s);
         chk("strobes", {14'h0, s[5:0]}, {14'h0, exp_stb[c]});
         chk("latched addr", saddr, 20'h1c0de);
         if (exp_stb[c] != 6'h0)
            chk("ale xcvr dir", {17'h0, s[8:6]}, {17'h0, c == 2 || c == 6, 2'b11});
      end
   endtask

   task automatic t_priority();
      logic [7:0] r0;
      dma_one(4'hf, 4'h1, {page[3:0], daddr});
      dma_one(4'h0, 4'h2, {page[7:4], daddr});
      r0 = row;
      dma_one(4'h0, 4'h4, {12'h0, r0});
      chk("row step", {12'h0, row}, {12'h0, r0 + 8'h01});
      dma_one(4'h0, 4'h8, {page[3:0], daddr});
   endtask

   task automatic t_lock();
      int hits;
      hits = 0;
      lk <= 1'b1;
      want <= 4'h2;
      repeat (300) begin
         @(negedge mclk);
         hits += (ack !== 4'h0) ? 1 : 0;
      end
      chk("grant under lock", 20'(hits), 20'h0);
      lk <= 1'b0;
      dma_one(4'h2, 4'h2, {page[7:4], daddr});
   endtask

   task automatic t_reset_mid();
      want <= 4'h1;
      wait_ack(1'b1);
      want <= 4'h0;
      reset_chk();
   endtask

   initial begin
      reset_chk();
      t_decode();
      t_priority();
      t_lock();
      t_reset_mid();
      t_decode();
      complete_run();
   end
endmodule
`default_nettype wire
